// ### hdl/sarc_ctrl.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module sarc_ctrl (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [31:0]           reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [31:0]           reg_rdata_o,
	input  wire logic                  rx_valid_i,
	input  wire sarc_pkg::sarc_rx_t    rx_frame_i,
	output logic                       rx_enable_o,
	output logic                       tx_start_o,
	output sarc_pkg::sarc_tx_t         tx_frame_o,
	input  wire logic                  tx_done_i,
	output logic                       irq_o
);

	//////////////////////////////////////////////////////////////////////////
	logic [5:0]             ctrl_q,   ctrl_d;
	logic [3:0]             irq_q,    irq_d;
	logic [3:0]             mask_q,   mask_d;
	logic [2:0]             ns_q,     ns_d;
	logic [2:0]             nr_q,     nr_d;
	logic                   auto_q,   auto_d;
	logic                   wait_q,   wait_d;
	logic [15:0]            rxctl_q,  rxctl_d;
	logic [31:0]            rdata_q,  rdata_d;
	logic                   start_q,  start_d;
	logic                   irqo_q,   irqo_d;
	sarc_pkg::sarc_tx_t     txf_q,    txf_d;
	sarc_pkg::sarc_state_t  st_q,     st_d;
	logic [3:0]             irq_set;
	logic                   rx_good;
	logic                   auto_info;
	logic                   poll;
	logic                   check_nr;
	logic [15:0]            cf;
	sarc_pkg::sarc_link_t   link_st;

	assign link_st   = sarc_pkg::sarc_link_t'(ctrl_q[sarc_pkg::CTRL_LS_HI:sarc_pkg::CTRL_LS_LO]);
	assign rx_good   = rx_valid_i && rx_frame_i.addr_ok && rx_frame_i.crc_ok;
	assign auto_info = auto_q && (link_st == sarc_pkg::SARC_LS_INFO);
	assign cf        = rx_frame_i.ctrl;
	assign poll      = cf[sarc_pkg::CF_PF];

	//////////////////////////////////////////////////////////////////////////
	// Frame handling, sequence counts and response choice
	always_comb begin
		ctrl_d   = ctrl_q;
		ns_d     = ns_q;
		nr_d     = nr_q;
		wait_d   = wait_q;
		rxctl_d  = rxctl_q;
		txf_d    = txf_q;
		start_d  = 1'b0;
		st_d     = st_q;
		auto_d   = auto_q;
		irq_set  = '0;
		check_nr = 1'b0;
		if (reg_wr_i && reg_addr_i == sarc_pkg::REG_CTRL) begin
			ctrl_d = reg_wdata_i[5:0];
		end
		if (reg_wr_i && reg_addr_i == sarc_pkg::REG_SEQ) begin
			ns_d = reg_wdata_i[sarc_pkg::SEQ_NS_LO +: 3];
			nr_d = reg_wdata_i[sarc_pkg::SEQ_NR_LO +: 3];
		end
		if (rx_good) begin
			if (auto_info && !rx_frame_i.ext_ctrl) begin
				if (!cf[0]) begin
					check_nr = 1'b1;
					// A full buffer discards the frame; the answer is RNR only while CTRL_GUARD is set
					if (ctrl_q[sarc_pkg::CTRL_RXEN] && !ctrl_q[sarc_pkg::CTRL_GUARD]) begin
						if (cf[3:1] == nr_q) begin
							nr_d = nr_q + sarc_pkg::SEQ_ONE;
							ctrl_d[sarc_pkg::CTRL_RXEN] = 1'b0;
							irq_set[sarc_pkg::IRQ_RX_FRAME] = 1'b1;
							rxctl_d = cf;
						end else begin
							irq_set[sarc_pkg::IRQ_SEQ_ERR] = 1'b1;
						end
					end
				end else if (cf[1:0] == sarc_pkg::CF_SUPV) begin
					check_nr = 1'b1;
				end else begin
					irq_set[sarc_pkg::IRQ_CPU_CMD] = 1'b1;
					rxctl_d = cf;
				end
				if (check_nr && wait_q) begin
					wait_d = 1'b0;
					if (cf[7:5] == ns_q + sarc_pkg::SEQ_ONE) begin
						ns_d = ns_q + sarc_pkg::SEQ_ONE;
						ctrl_d[sarc_pkg::CTRL_PEND] = 1'b0;
						irq_set[sarc_pkg::IRQ_TX_ACK] = 1'b1;
					end else if (cf[7:5] != ns_q) begin
						irq_set[sarc_pkg::IRQ_SEQ_ERR] = 1'b1;
					end
				end
				// Only a poll opens the line for us; nothing is sent otherwise
				if (check_nr && poll && st_q == sarc_pkg::SARC_ST_IDLE) begin
					start_d = 1'b1;
					txf_d   = '0;
					if (ctrl_d[sarc_pkg::CTRL_PEND] && !wait_d) begin
						// Pending frame goes out here, the first time and again if unacked or rejected
						txf_d.info = 1'b1;
						txf_d.ctrl = {8'h00, nr_d, 1'b1, ns_d, 1'b0};
						wait_d     = 1'b1;
					end else if (ctrl_d[sarc_pkg::CTRL_GUARD]) begin
						txf_d.ctrl = {8'h00, nr_d, 1'b1, sarc_pkg::CF_S_RNR, sarc_pkg::CF_SUPV};
					end else begin
						txf_d.ctrl = {8'h00, nr_d, 1'b1, sarc_pkg::CF_S_RR, sarc_pkg::CF_SUPV};
					end
				end
			end else if (!auto_q) begin
				// No decode here; the processor sees every frame it enabled for
				if (ctrl_q[sarc_pkg::CTRL_RXEN]) begin
					rxctl_d = cf;
					ctrl_d[sarc_pkg::CTRL_RXEN] = 1'b0;
					irq_set[sarc_pkg::IRQ_RX_FRAME] = 1'b1;
				end
			end else begin
				rxctl_d = cf;
				irq_set[sarc_pkg::IRQ_CPU_CMD] = 1'b1;
			end
		end
		if (!auto_q && st_q == sarc_pkg::SARC_ST_IDLE && reg_wr_i
			&& reg_addr_i == sarc_pkg::REG_TX_CMD && reg_wdata_i[sarc_pkg::TXC_GO]) begin
			start_d        = 1'b1;
			txf_d.ctrl     = reg_wdata_i[15:0];
			txf_d.ext_ctrl = reg_wdata_i[sarc_pkg::TXC_EXT_CTRL];
			txf_d.ext_addr = reg_wdata_i[sarc_pkg::TXC_EXT_ADDR];
			txf_d.info     = 1'b0;
		end
		if (st_q == sarc_pkg::SARC_ST_TX && tx_done_i) begin
			st_d = sarc_pkg::SARC_ST_IDLE;
		end
		if (start_d) begin
			st_d = sarc_pkg::SARC_ST_TX;
		end
		if (st_q == sarc_pkg::SARC_ST_IDLE && !rx_valid_i && !start_d) begin
			auto_d = ctrl_q[sarc_pkg::CTRL_AUTO];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q  <= sarc_pkg::CTRL_RST;
			ns_q    <= sarc_pkg::SEQ_RST;
			nr_q    <= sarc_pkg::SEQ_RST;
			wait_q  <= 1'b0;
			rxctl_q <= 16'h0000;
			txf_q   <= '0;
			start_q <= 1'b0;
			st_q    <= sarc_pkg::SARC_ST_IDLE;
			auto_q  <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			ns_q    <= ns_d;
			nr_q    <= nr_d;
			wait_q  <= wait_d;
			rxctl_q <= rxctl_d;
			txf_q   <= txf_d;
			start_q <= start_d;
			st_q    <= st_d;
			auto_q  <= auto_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register reads and interrupt; a new event beats a clearing read
	always_comb begin
		irq_d  = irq_q;
		mask_d = mask_q;
		if (reg_rd_i && reg_addr_i == sarc_pkg::REG_IRQ_STAT) begin
			irq_d = '0;
		end
		irq_d = irq_d | irq_set;
		if (reg_wr_i && reg_addr_i == sarc_pkg::REG_IRQ_MASK) begin
			mask_d = reg_wdata_i[3:0];
		end
		irqo_d  = |(irq_d & mask_d);
		rdata_d = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				sarc_pkg::REG_CTRL:     rdata_d = {26'h0, ctrl_q};
				sarc_pkg::REG_IRQ_STAT: rdata_d = {28'h0, irq_q};
				sarc_pkg::REG_IRQ_MASK: rdata_d = {28'h0, mask_q};
				sarc_pkg::REG_SEQ:      rdata_d = {21'h0, wait_q, st_q == sarc_pkg::SARC_ST_TX,
				                                   auto_q, 1'b0, nr_q, 1'b0, ns_q};
				sarc_pkg::REG_RX_CTRL:  rdata_d = {16'h0, rxctl_q};
				default:                rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_q   <= sarc_pkg::IRQ_RST;
			mask_q  <= sarc_pkg::IRQ_RST;
			irqo_q  <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			irq_q   <= irq_d;
			mask_q  <= mask_d;
			irqo_q  <= irqo_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign rx_enable_o = ctrl_q[sarc_pkg::CTRL_RXEN];
	assign tx_start_o  = start_q;
	assign tx_frame_o  = txf_q;
	assign irq_o       = irqo_q;

	//////////////////////////////////////////////////////////////////////////
	AST_RR_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && cf[1:0] == sarc_pkg::CF_SUPV && poll
		 && !wait_q && !ctrl_q[sarc_pkg::CTRL_PEND] && !ctrl_q[sarc_pkg::CTRL_GUARD]
		 && !reg_wr_i && st_q == sarc_pkg::SARC_ST_IDLE)
		|=> tx_start_o && tx_frame_o.ctrl[3:0] == 4'h1 && !tx_frame_o.info)
		else $error("RR not answered to poll");
	AST_RNR_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && cf[1:0] == sarc_pkg::CF_SUPV && poll
		 && !wait_q && !ctrl_q[sarc_pkg::CTRL_PEND] && ctrl_q[sarc_pkg::CTRL_GUARD]
		 && !reg_wr_i && st_q == sarc_pkg::SARC_ST_IDLE)
		|=> tx_start_o && tx_frame_o.ctrl[3:0] == 4'h5)
		else $error("RNR not answered to poll");
	AST_POLLED_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		tx_start_o && $past(auto_q) |-> $past(rx_good) && $past(poll))
		else $error("Auto mode sent without a poll");
	AST_QUIET_POLL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && cf[1:0] == sarc_pkg::CF_SUPV
		 && !wait_q && !reg_rd_i) |=> $stable(irq_q))
		else $error("Routine poll raised an interrupt");
	AST_FLEX_SILENT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!auto_q && rx_good && !reg_wr_i) |=> !tx_start_o
		##1 (!tx_start_o || $past(reg_wr_i && reg_addr_i == sarc_pkg::REG_TX_CMD)))
		else $error("Software mode answered a frame");
	AST_RX_ACCEPT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && !cf[0] && cf[3:1] == nr_q
		 && ctrl_q[sarc_pkg::CTRL_RXEN] && !ctrl_q[sarc_pkg::CTRL_GUARD] && !reg_wr_i)
		|=> nr_q == $past(nr_q) + 3'h1 && !rx_enable_o && irq_q[sarc_pkg::IRQ_RX_FRAME])
		else $error("Good I frame not taken");
	AST_ACK: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && cf[1:0] == sarc_pkg::CF_SUPV
		 && wait_q && cf[7:5] == ns_q + 3'h1 && !reg_wr_i)
		|=> ns_q == $past(ns_q) + 3'h1 && !ctrl_q[sarc_pkg::CTRL_PEND] && !wait_q)
		else $error("Positive ack not applied");
	AST_MODE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(st_q == sarc_pkg::SARC_ST_TX) |=> $stable(auto_q))
		else $error("Mode changed inside a frame");
	AST_NONINFO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_q && link_st != sarc_pkg::SARC_LS_INFO && rx_good)
		|=> irq_q[sarc_pkg::IRQ_CPU_CMD] && !tx_start_o)
		else $error("Non-info state frame not handed over");
	// An I frame only leaves while the link is in information transfer
	AST_INFO_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(tx_start_o && tx_frame_o.info) |-> $past(auto_info))
		else $error("Information frame outside information transfer");
	AST_I_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(auto_info && rx_good && !rx_frame_i.ext_ctrl && cf[1:0] == sarc_pkg::CF_SUPV && poll
		 && !wait_q && ctrl_q[sarc_pkg::CTRL_PEND] && !reg_wr_i
		 && st_q == sarc_pkg::SARC_ST_IDLE)
		|=> tx_start_o && tx_frame_o.info && !tx_frame_o.ctrl[0] && wait_q)
		else $error("I frame not sent to poll with a frame pending");
	AST_SOFT_TX: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!auto_q && st_q == sarc_pkg::SARC_ST_IDLE && reg_wr_i
		 && reg_addr_i == sarc_pkg::REG_TX_CMD && reg_wdata_i[sarc_pkg::TXC_GO])
		|=> tx_start_o && tx_frame_o.ctrl == $past(reg_wdata_i[15:0]) && !tx_frame_o.info)
		else $error("Software mode did not start an unpolled frame");
	AST_SOFT_EXT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!auto_q && st_q == sarc_pkg::SARC_ST_IDLE && reg_wr_i
		 && reg_addr_i == sarc_pkg::REG_TX_CMD && reg_wdata_i[sarc_pkg::TXC_GO])
		|=> tx_frame_o.ext_ctrl == $past(reg_wdata_i[sarc_pkg::TXC_EXT_CTRL])
		 && tx_frame_o.ext_addr == $past(reg_wdata_i[sarc_pkg::TXC_EXT_ADDR]))
		else $error("Extended field flags not carried to the frame");
	AST_SOFT_KEEP_SEQ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!auto_q && rx_good && !reg_wr_i) |=> $stable(ns_q) && $stable(nr_q) && $stable(wait_q))
		else $error("Software mode touched the sequence counts");
	AST_SOFT_HANDOVER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!auto_q && rx_good && ctrl_q[sarc_pkg::CTRL_RXEN] && !reg_wr_i)
		|=> !rx_enable_o && irq_q[sarc_pkg::IRQ_RX_FRAME] && rxctl_q == $past(cf))
		else $error("Software mode frame not handed to the processor");
	AST_BUSY_QUIET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(st_q == sarc_pkg::SARC_ST_TX) |=> !tx_start_o)
		else $error("New frame started while one is still going out");

endmodule : sarc_ctrl

// ### hdl/sarc_pkg.sv
package sarc_pkg;

	localparam int          REG_AW        = 8;
	localparam int          REG_DW        = 32;
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_IRQ_STAT  = 8'h04;
	localparam logic [7:0]  REG_IRQ_MASK  = 8'h08;
	localparam logic [7:0]  REG_SEQ       = 8'h0C;
	localparam logic [7:0]  REG_TX_CMD    = 8'h10;
	localparam logic [7:0]  REG_RX_CTRL   = 8'h14;

	// Control register layout
	localparam int          CTRL_W        = 6;
	localparam int          CTRL_AUTO     = 0;
	localparam int          CTRL_PEND     = 1;
	localparam int          CTRL_GUARD    = 2;
	localparam int          CTRL_RXEN     = 3;
	localparam int          CTRL_LS_LO    = 4;
	localparam int          CTRL_LS_HI    = 5;
	localparam logic [5:0]  CTRL_RST      = 6'h00;

	// Interrupt status and mask layout
	localparam int          IRQ_W         = 4;
	localparam int          IRQ_TX_ACK    = 0;
	localparam int          IRQ_RX_FRAME  = 1;
	localparam int          IRQ_SEQ_ERR   = 2;
	localparam int          IRQ_CPU_CMD   = 3;
	localparam logic [3:0]  IRQ_RST       = 4'h0;

	// Sequence / state register layout
	localparam int          SEQ_NS_LO     = 0;
	localparam int          SEQ_NR_LO     = 4;
	localparam int          SEQ_MODE      = 8;
	localparam int          SEQ_BUSY      = 9;
	localparam int          SEQ_WAIT      = 10;
	localparam logic [2:0]  SEQ_RST       = 3'h0;

	// Transmit command register layout
	localparam int          TXC_EXT_CTRL  = 16;
	localparam int          TXC_EXT_ADDR  = 17;
	localparam int          TXC_GO        = 31;

	// Basic control field encodings
	localparam int          CF_PF         = 4;
	localparam logic [1:0]  CF_SUPV       = 2'h1;
	localparam logic [1:0]  CF_S_RR       = 2'h0;
	localparam logic [1:0]  CF_S_RNR      = 2'h1;
	localparam logic [2:0]  SEQ_ONE       = 3'h1;

	typedef enum logic [1:0] {
		SARC_LS_DISC,
		SARC_LS_INIT,
		SARC_LS_FRMR,
		SARC_LS_INFO
	} sarc_link_t;

	typedef enum logic {
		SARC_ST_IDLE,
		SARC_ST_TX
	} sarc_state_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic        ext_ctrl;
		logic        addr_ok;
		logic        crc_ok;
	} sarc_rx_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic        ext_ctrl;
		logic        ext_addr;
		logic        info;
	} sarc_tx_t;

endpackage : sarc_pkg

// ### sim/sarc_framer_model.sv
`timescale 1ns/1ps

// Stands in for the bit-level framer and the primary station beyond it
module sarc_framer_model (
	input  wire logic               ref_clk_i,
	input  wire logic               rst_b_i,
	input  wire logic               tx_start_i,
	input  wire logic [31:0]        lat_i,
	output logic                    tx_done_o,
	output logic                    rx_valid_o,
	output sarc_pkg::sarc_rx_t      rx_frame_o
);
	int cnt_q = 0;

	initial begin
		tx_done_o  = 1'b0;
		rx_valid_o = 1'b0;
		rx_frame_o = '0;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Done comes only after a start, after lat_i cycles, so slow lines are exercised
	always @(posedge ref_clk_i) begin
		tx_done_o <= 1'b0;
		if (!rst_b_i) begin
			cnt_q <= 0;
		end else if (tx_start_i === 1'b1) begin
			cnt_q <= lat_i;
		end else if (cnt_q == 1) begin
			tx_done_o <= 1'b1;
			cnt_q     <= 0;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Descriptor is inverted once released, so a stale value is never mistaken for a new one
	task automatic put(input sarc_pkg::sarc_rx_t fr);
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b1;
		rx_frame_o <= fr;
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b0;
		rx_frame_o <= ~fr;
	endtask : put
endmodule : sarc_framer_model

// ### sim/tb_sdlc_auto_response_control.sv
`timescale 1ns/1ps

module tb_sdlc_auto_response_control;
	logic               ref_clk_i   = 1'b0;
	logic               rst_b_i     = 1'b0;
	logic [7:0]         reg_addr_i  = 8'h00;
	logic [31:0]        reg_wdata_i = 32'h0;
	logic               reg_wr_i    = 1'b0;
	logic               reg_rd_i    = 1'b0;
	logic [31:0]        reg_rdata_o;
	logic               rx_valid_i;
	sarc_pkg::sarc_rx_t rx_frame_i;
	logic               rx_enable_o;
	logic               tx_start_o;
	sarc_pkg::sarc_tx_t tx_frame_o;
	logic               tx_done_i;
	logic               irq_o;
	int                 lat         = 1;
	int                 n_fail      = 0;
	int                 checked     = 0;
	logic               hit;
	logic [18:0]        f;

	always #5 ref_clk_i = ~ref_clk_i;

	sarc_ctrl dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
		.rx_enable_o(rx_enable_o), .tx_start_o(tx_start_o), .tx_frame_o(tx_frame_o),
		.tx_done_i(tx_done_i), .irq_o(irq_o));

	sarc_framer_model fm (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tx_start_i(tx_start_o),
		.lat_i(lat), .tx_done_o(tx_done_i), .rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i));

	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(n, e, reg_rdata_o);
	endtask : rd

	// Window of 20 cycles from the edge that took the request; the pulse stands one cycle only
	task automatic wait_tx;
		hit = 1'b0;
		for (int i = 0; i < 20 && !hit; i++) begin
			#1;
			if (tx_start_o === 1'b1) begin
				hit = 1'b1;
				f   = tx_frame_o;
			end
			@(posedge ref_clk_i);
		end
	endtask : wait_tx

	task automatic wait_irq;
		for (int i = 0; i < 50; i++) begin
			@(posedge ref_clk_i);
			#1;
			if (irq_o === 1'b1) return;
		end
		n_fail++;
		$display("unexpected irq_o wait expired");
		complete_run();
	endtask : wait_irq

	// Good frame from the primary; busy is let to clear before the next one
	task automatic poll(input logic [15:0] c, input logic eh, input logic [18:0] ef);
		fm.put({c, 3'b011});
		wait_tx();
		chk("tx_start_o", eh, hit);
		if (eh) chk("tx_frame_o", ef, f);
		repeat (12) @(posedge ref_clk_i);
		#1;
	endtask : poll

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(sarc_pkg::REG_CTRL, 32'h0, "ctrl");
		rd(sarc_pkg::REG_IRQ_MASK, 32'h0, "mask");
		rd(sarc_pkg::REG_SEQ, 32'h0, "seq");
		rd(8'h1C, 32'h0, "unmapped");
		wr(sarc_pkg::REG_IRQ_MASK, 32'h0000000F);
		for (int g = 0; g < 2; g++) begin
			wr(sarc_pkg::REG_CTRL, 32'h31 | (g << 2));
			repeat (3) @(posedge ref_clk_i);
			poll(16'h0011, 1'b1, {(g == 0) ? 16'h0011 : 16'h0015, 3'b000});
			chk("irq_o", 1'b0, irq_o);
		end
		rd(sarc_pkg::REG_IRQ_STAT, 32'h0, "stat");
		lat = 6;
		wr(sarc_pkg::REG_CTRL, 32'h33);
		poll(16'h0011, 1'b1, {16'h0010, 3'b001});
		poll(16'h0011, 1'b1, {16'h0010, 3'b001});
		fm.put({16'h0031, 3'b011});
		wait_irq();
		repeat (12) @(posedge ref_clk_i);
		rd(sarc_pkg::REG_IRQ_STAT, 32'h1, "stat");
		rd(sarc_pkg::REG_SEQ, 32'h101, "seq");
		rd(sarc_pkg::REG_CTRL, 32'h31, "ctrl");
		@(posedge ref_clk_i);
		#1;
		chk("irq_o", 1'b0, irq_o);
		lat = 1;
		wr(sarc_pkg::REG_CTRL, 32'h39);
		poll(16'h0020, 1'b0, 19'h0);
		chk("irq_o", 1'b1, irq_o);
		chk("rx_enable_o", 1'b0, rx_enable_o);
		rd(sarc_pkg::REG_IRQ_STAT, 32'h2, "stat");
		rd(sarc_pkg::REG_SEQ, 32'h111, "seq");
		rd(sarc_pkg::REG_RX_CTRL, 32'h20, "rx_ctrl");
		// Masked event must stay sticky while the line stays low
		wr(sarc_pkg::REG_IRQ_MASK, 32'h0);
		wr(sarc_pkg::REG_CTRL, 32'h01);
		poll(16'h0011, 1'b0, 19'h0);
		chk("irq_o", 1'b0, irq_o);
		rd(sarc_pkg::REG_IRQ_STAT, 32'h8, "stat");
		wr(sarc_pkg::REG_IRQ_MASK, 32'h0000000F);
		wr(sarc_pkg::REG_CTRL, 32'h38);
		repeat (3) @(posedge ref_clk_i);
		poll(16'h0011, 1'b0, 19'h0);
		rd(sarc_pkg::REG_SEQ, 32'h011, "seq");
		rd(sarc_pkg::REG_RX_CTRL, 32'h11, "rx_ctrl");
		rd(sarc_pkg::REG_IRQ_STAT, 32'h2, "stat");
		wr(sarc_pkg::REG_TX_CMD, 32'h80031234);
		wait_tx();
		chk("tx_start_o", 1'b1, hit);
		chk("tx_frame_o", {16'h1234, 3'b110}, f);
		repeat (5) @(posedge ref_clk_i);
		complete_run();
	end
endmodule : tb_sdlc_auto_response_control
